// [hdl/tcit_pkg.sv]
// Purpose: constants and types for the three channel interval timer
// Assumes: byte-wide host port, decimal offsets from card base
// Notes: one package shared by the design file and the verification files
package tcit_pkg;
   localparam logic [5:0] TCIT_OFF_CNT0 = 6'h18;
   localparam logic [5:0] TCIT_OFF_CNT1 = 6'h19;
   localparam logic [5:0] TCIT_OFF_CNT2 = 6'h1A;
   localparam logic [5:0] TCIT_OFF_CTRL = 6'h1B;
   localparam int TCIT_SEL_POS = 6;
   localparam int TCIT_FMT_POS = 4;
   localparam int TCIT_MODE_POS = 1;
   localparam int TCIT_BCD_POS = 0;
   localparam int TCIT_CNTL_POS = 5;
   localparam int TCIT_STAL_POS = 4;
   localparam logic [1:0] TCIT_SEL_RB = 2'h3;
   localparam logic [1:0] TCIT_FMT_LATCH = 2'h0;
   localparam logic [1:0] TCIT_FMT_LO = 2'h1;
   localparam logic [1:0] TCIT_FMT_HI = 2'h2;
   localparam logic [1:0] TCIT_FMT_BOTH = 2'h3;
   localparam logic [15:0] TCIT_COUNT_RST = 16'h0000;
   localparam logic [5:0] TCIT_CTRL_RST = 6'h00;
   localparam int TCIT_SYS_MHZ = 250;
   localparam int TCIT_OSC_MHZ = 10;
   // half period of the on-board counter clock in system cycles
   localparam int TCIT_OSC_HALF = TCIT_SYS_MHZ / (2 * TCIT_OSC_MHZ);
   typedef enum logic [2:0] {
      TCIT_M0, TCIT_M1, TCIT_M2, TCIT_M3, TCIT_M4, TCIT_M5
   } tcit_mode_t;
   typedef struct packed {
      logic [1:0] fmt;
      logic [2:0] mode;
      logic bcd;
   } tcit_ctrl_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } tcit_bus_t;
endpackage : tcit_pkg

// [hdl/tcit_timer.sv]
// Purpose: three 16-bit down counters with control word, latch and read-back
// Assumes: host accesses are one-cycle strobes on the system clock
// Notes: counter clock and gate pins are synchronised and edge detected
//Contract
// - three 16-bit down counters, each with clock, gate, output; counts 2..65535
// - internal clock source is a 10 MHz divider
// - counter 1 may be clocked by counter 0 output for 32-bit timing
// - data ports at offsets 24, 25, 26; control word at 27
// - control bits 7:6 pick counter; 11 means read-back
// - control bits 5:4 give latch, low, high, or low-then-high
// - control bits 3:1 give mode, bit 3 ignored for modes 2 and 3
// - control bit 0 selects binary or decimal counting
// - read-back bit 5 low latches counts, bit 4 low latches statuses
// - status byte: output, null count, then format, mode, type
// - status is read only after latching, by next data read
// - one read-back latches several counts like separate latch commands
// - latch copies count to hold register; reads return it
// - control words and count writes accepted in any order
// - mode 0: out low, high at terminal count, first byte halts
// - mode 1: gate edge fires one-shot, retriggerable, count used next trigger
// - mode 2: one-clock low pulse per period, gate low forces high
// - mode 3: decrement by two, toggle out, odd count split (N+1)/2
// - mode 4: out high, one-clock low at terminal count, gate inhibits
// - mode 5: gate edge starts count, one-clock low strobe, retriggerable
// - outputs of counters 1 and 2 go to interrupt logic
// - gate held high internally unless pin drives it
`timescale 1ns/1ps
module tcit_timer
   import tcit_pkg::*;
#(
   parameter int NCH = 3 // counters on the card
) (
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic ce, // clock enable
   input wire tcit_bus_t bus, // host register access
   output logic [7:0] rdata, // read data
   input wire logic [NCH-1:0] ext_clk, // external counter clocks
   input wire logic [NCH-1:0] ext_clk_sel, // pick external clock
   input wire logic cascade_sel, // counter 1 clocked by counter 0 output
   input wire logic [NCH-1:0] gate_pin, // gate pins
   input wire logic [NCH-1:0] gate_pin_used, // pin drives gate, else high
   output logic [NCH-1:0] cnt_out, // counter outputs
   output logic irq_src_c1, // counter 1 output to interrupt logic
   output logic irq_src_c2 // counter 2 output to interrupt logic
);
   logic [$clog2(TCIT_OSC_HALF)-1:0] div_r;
   logic osc_r;
   logic [NCH-1:0] ck_s1_r, ck_s2_r, ck_d_r, gt_s1_r, gt_s2_r;
   logic [NCH-1:0] ckin, fall, gate, gate_rise;
   logic [NCH-1:0] wr_data, rd_data, ctl_hit, cnt_lat, sta_lat;
   tcit_ctrl_t ctrl_r [NCH];
   logic [15:0] init_r [NCH];
   logic [15:0] cnt_r [NCH];
   logic [15:0] hold_r [NCH];
   logic [7:0] stat_r [NCH];
   logic [NCH-1:0] hold_v_r, stat_v_r, wr_hi_r, rd_hi_r;
   logic [NCH-1:0] null_r, arm_r, run_r, trig_r, ph_r;
   logic [5:0] cw;
   logic [1:0] csel;

   assign cw = bus.wdata[5:0];
   assign csel = bus.wdata[TCIT_SEL_POS +: 2];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         div_r <= '0;
         osc_r <= 1'b0;
      end else if (ce) begin
         if (div_r == ($clog2(TCIT_OSC_HALF))'(TCIT_OSC_HALF - 1)) begin
            div_r <= '0;
            osc_r <= ~osc_r;
         end else begin
            div_r <= div_r + 1'b1;
         end
      end
   end

   // pins pass two flops before use
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ck_s1_r <= '0;
         ck_s2_r <= '0;
         gt_s1_r <= '0;
         gt_s2_r <= '0;
      end else if (ce) begin
         ck_s1_r <= ext_clk;
         ck_s2_r <= ck_s1_r;
         gt_s1_r <= gate_pin;
         gt_s2_r <= gt_s1_r;
      end
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         ckin[i] = ext_clk_sel[i] ? ck_s2_r[i] : osc_r;
         gate[i] = gate_pin_used[i] ? gt_s2_r[i] : 1'b1;
      end
      if (cascade_sel) begin
         ckin[1] = cnt_out[0];
      end
   end

   logic [NCH-1:0] gate_d_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ck_d_r <= '0;
         gate_d_r <= '1;
      end else if (ce) begin
         ck_d_r <= ckin;
         gate_d_r <= gate;
      end
   end
   assign fall = ck_d_r & ~ckin;
   assign gate_rise = gate & ~gate_d_r;

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         wr_data[i] = bus.wr && bus.addr == TCIT_OFF_CNT0 + 6'(i);
         rd_data[i] = bus.rd && bus.addr == TCIT_OFF_CNT0 + 6'(i);
         ctl_hit[i] = bus.wr && bus.addr == TCIT_OFF_CTRL && csel == 2'(i);
         cnt_lat[i] = (ctl_hit[i] && bus.wdata[TCIT_FMT_POS +: 2] == TCIT_FMT_LATCH)
                      || (bus.wr && bus.addr == TCIT_OFF_CTRL && csel == TCIT_SEL_RB
                          && !bus.wdata[TCIT_CNTL_POS] && bus.wdata[1 + i]);
         sta_lat[i] = bus.wr && bus.addr == TCIT_OFF_CTRL && csel == TCIT_SEL_RB
                      && !bus.wdata[TCIT_STAL_POS] && bus.wdata[1 + i];
      end
   end

   // BCD decrement of one or more; binary otherwise
   function automatic logic [15:0] tcit_dec(input logic [15:0] v, input logic [1:0] n,
                                            input logic bcd);
      logic [15:0] r;
      r = v;
      for (int k = 0; k < 3; k++) begin
         if (2'(k) < n) begin
            if (!bcd) begin
               r = r - 16'h0001;
            end else if (r[3:0] != 4'h0) begin
               r[3:0] = r[3:0] - 4'h1;
            end else if (r[7:4] != 4'h0) begin
               r[7:0] = {r[7:4] - 4'h1, 4'h9};
            end else if (r[11:8] != 4'h0) begin
               r[11:0] = {r[11:8] - 4'h1, 8'h99};
            end else if (r[15:12] != 4'h0) begin
               r = {r[15:12] - 4'h1, 12'h999};
            end else begin
               r = 16'h9999;
            end
         end
      end
      return r;
   endfunction : tcit_dec

   function automatic tcit_mode_t tcit_md(input logic [2:0] m);
      unique case (m)
         3'h0: return TCIT_M0;
         3'h1: return TCIT_M1;
         3'h2, 3'h6: return TCIT_M2;
         3'h3, 3'h7: return TCIT_M3;
         3'h4: return TCIT_M4;
         default: return TCIT_M5;
      endcase
   endfunction : tcit_md

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      tcit_mode_t md;
      logic [15:0] ld;
      assign md = tcit_md(ctrl_r[i].mode);
      assign ld = init_r[i];

      // host side: control word, count writes
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            ctrl_r[i] <= TCIT_CTRL_RST;
            init_r[i] <= TCIT_COUNT_RST;
            wr_hi_r[i] <= 1'b0;
            arm_r[i] <= 1'b0;
            null_r[i] <= 1'b0;
         end else if (ce) begin
            if (ctl_hit[i] && bus.wdata[TCIT_FMT_POS +: 2] != TCIT_FMT_LATCH) begin
               ctrl_r[i] <= cw;
               wr_hi_r[i] <= 1'b0;
               arm_r[i] <= 1'b0;
            end else if (wr_data[i]) begin
               unique case (ctrl_r[i].fmt)
                  TCIT_FMT_LO: begin
                     init_r[i] <= {8'h00, bus.wdata};
                     arm_r[i] <= 1'b1;
                     null_r[i] <= 1'b1;
                  end
                  TCIT_FMT_HI: begin
                     init_r[i] <= {bus.wdata, 8'h00};
                     arm_r[i] <= 1'b1;
                     null_r[i] <= 1'b1;
                  end
                  default: begin
                     // host keeps byte pairing; first byte halts
                     if (!wr_hi_r[i]) begin
                        init_r[i][7:0] <= bus.wdata;
                        arm_r[i] <= 1'b0;
                     end else begin
                        init_r[i][15:8] <= bus.wdata;
                        arm_r[i] <= 1'b1;
                        null_r[i] <= 1'b1;
                     end
                     wr_hi_r[i] <= ~wr_hi_r[i];
                  end
               endcase
            end else if (fall[i] && run_r[i] && !trig_r[i]) begin
               null_r[i] <= 1'b0; // count now in counting element
            end
         end
      end

      // counting element, one falling edge per step
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            cnt_r[i] <= TCIT_COUNT_RST;
            cnt_out[i] <= 1'b1;
            run_r[i] <= 1'b0;
            trig_r[i] <= 1'b0;
            ph_r[i] <= 1'b0;
         end else if (ce) begin
            if (ctl_hit[i] && bus.wdata[TCIT_FMT_POS +: 2] != TCIT_FMT_LATCH) begin
               cnt_out[i] <= bus.wdata[3:1] != 3'h0; // low in mode 0
               run_r[i] <= 1'b0;
               trig_r[i] <= 1'b0;
            end else begin
               if (wr_data[i] && (md == TCIT_M0 || md == TCIT_M4)) begin
                  trig_r[i] <= 1'b1; // reload on next clock
                  if (md == TCIT_M0) cnt_out[i] <= 1'b0;
               end
               if (gate_rise[i] && (md == TCIT_M1 || md == TCIT_M5 || md == TCIT_M2
                                    || md == TCIT_M3)) begin
                  trig_r[i] <= 1'b1; // retrigger
               end
               if (arm_r[i] && !run_r[i] && (md == TCIT_M2 || md == TCIT_M3)) begin
                  trig_r[i] <= 1'b1;
               end
               if (fall[i] && arm_r[i]) begin
                  if (trig_r[i]) begin
                     cnt_r[i] <= ld;
                     run_r[i] <= 1'b1;
                     trig_r[i] <= 1'b0;
                     ph_r[i] <= 1'b0;
                     if (md == TCIT_M1) cnt_out[i] <= 1'b0;
                     if (md == TCIT_M2 || md == TCIT_M3) cnt_out[i] <= 1'b1;
                  end else begin
                     unique case (md)
                        TCIT_M0, TCIT_M1: begin
                           cnt_r[i] <= tcit_dec(cnt_r[i], 2'd1, ctrl_r[i].bcd);
                           if (cnt_r[i] == 16'h0001 && run_r[i]) begin
                              cnt_out[i] <= 1'b1;
                              run_r[i] <= md == TCIT_M0;
                           end
                        end
                        TCIT_M2: begin
                           if (!gate[i]) begin
                              cnt_out[i] <= 1'b1;
                           end else if (cnt_r[i] == 16'h0002) begin
                              cnt_r[i] <= 16'h0001;
                              cnt_out[i] <= 1'b0;
                           end else if (cnt_r[i] == 16'h0001) begin
                              cnt_r[i] <= ld;
                              cnt_out[i] <= 1'b1;
                           end else begin
                              cnt_r[i] <= tcit_dec(cnt_r[i], 2'd1, ctrl_r[i].bcd);
                           end
                        end
                        TCIT_M3: begin
                           if (gate[i]) begin
                              if (cnt_r[i] <= 16'h0002 || (cnt_r[i] == 16'h0003
                                  && !cnt_out[i])) begin
                                 cnt_r[i] <= ld;
                                 cnt_out[i] <= ~cnt_out[i];
                                 ph_r[i] <= 1'b0;
                              end else if (cnt_r[i][0] && !ph_r[i]) begin
                                 cnt_r[i] <= tcit_dec(cnt_r[i], cnt_out[i] ? 2'd1 : 2'd3,
                                                      ctrl_r[i].bcd);
                                 ph_r[i] <= 1'b1;
                              end else begin
                                 cnt_r[i] <= tcit_dec(cnt_r[i], 2'd2, ctrl_r[i].bcd);
                              end
                           end else begin
                              cnt_out[i] <= 1'b1;
                           end
                        end
                        default: begin // strobe modes
                           if (gate[i] || md == TCIT_M5) begin
                              cnt_r[i] <= tcit_dec(cnt_r[i], 2'd1, ctrl_r[i].bcd);
                           end
                           cnt_out[i] <= !(run_r[i] && cnt_r[i] == 16'h0001
                                           && (gate[i] || md == TCIT_M5));
                           if (!cnt_out[i]) run_r[i] <= 1'b0;
                        end
                     endcase
                  end
               end
            end
         end
      end

      // hold register, status latch, read byte order
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            hold_r[i] <= TCIT_COUNT_RST;
            hold_v_r[i] <= 1'b0;
            stat_r[i] <= 8'h00;
            stat_v_r[i] <= 1'b0;
            rd_hi_r[i] <= 1'b0;
         end else if (ce) begin
            if (ctl_hit[i] && bus.wdata[TCIT_FMT_POS +: 2] != TCIT_FMT_LATCH) begin
               rd_hi_r[i] <= 1'b0;
               hold_v_r[i] <= 1'b0;
               stat_v_r[i] <= 1'b0;
            end
            if (cnt_lat[i] && !hold_v_r[i]) begin
               hold_r[i] <= cnt_r[i];
               hold_v_r[i] <= 1'b1;
            end
            if (sta_lat[i] && !stat_v_r[i]) begin
               stat_r[i] <= {cnt_out[i], null_r[i], ctrl_r[i]};
               stat_v_r[i] <= 1'b1;
            end
            if (rd_data[i]) begin
               if (stat_v_r[i]) begin
                  stat_v_r[i] <= 1'b0;
               end else if (ctrl_r[i].fmt == TCIT_FMT_BOTH) begin
                  rd_hi_r[i] <= ~rd_hi_r[i];
                  if (rd_hi_r[i]) hold_v_r[i] <= 1'b0;
               end else begin
                  hold_v_r[i] <= 1'b0;
               end
            end
         end
      end
   end

   // data output register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (ce) begin
         rdata <= 8'h00;
         for (int i = 0; i < NCH; i++) begin
            if (rd_data[i]) begin
               if (stat_v_r[i]) begin
                  rdata <= stat_r[i];
               end else if (ctrl_r[i].fmt == TCIT_FMT_HI
                            || (ctrl_r[i].fmt == TCIT_FMT_BOTH && rd_hi_r[i])) begin
                  rdata <= hold_v_r[i] ? hold_r[i][15:8] : cnt_r[i][15:8];
               end else begin
                  rdata <= hold_v_r[i] ? hold_r[i][7:0] : cnt_r[i][7:0];
               end
            end
         end
      end
   end

   assign irq_src_c1 = cnt_out[1];
   assign irq_src_c2 = cnt_out[2];

   // status read on counter 0 returns the whole latched status byte
   property p_stat_read;
      @(posedge clock) disable iff (rst)
         ce && rd_data[0] && stat_v_r[0] |=> rdata == stat_r[0];
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");

   property p_hold;
      @(posedge clock) disable iff (rst)
         ce && cnt_lat[0] && !hold_v_r[0] |=> hold_v_r[0] && hold_r[0] == $past(cnt_r[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("latch missed count");

   property p_m0_low;
      @(posedge clock) disable iff (rst)
         ce && ctl_hit[0] && bus.wdata[3:1] == 3'h0 && bus.wdata[5:4] != 2'h0
         |=> !cnt_out[0];
   endproperty
   a_m0_low: assert property (p_m0_low) else $error("mode 0 out not low");

   property p_irq;
      @(posedge clock) irq_src_c2 == cnt_out[2] && irq_src_c1 == cnt_out[1];
   endproperty
   a_irq: assert property (p_irq) else $error("irq source mismatch");

   // gate low in mode 2 forces the output high at the next counter clock
   property p_gate_hi;
      @(posedge clock) disable iff (rst)
         ce && fall[1] && arm_r[1] && !trig_r[1] && !ctl_hit[1] && !gate[1]
         && g_ch[1].md == TCIT_M2 |=> cnt_out[1];
   endproperty
   a_gate_hi: assert property (p_gate_hi) else $error("gate low left output low");

   // every mode but mode 0 starts with the output high
   property p_cfg_out;
      @(posedge clock) disable iff (rst)
         ce && ctl_hit[1] && bus.wdata[5:4] != 2'h0 && bus.wdata[3:1] != 3'h0
         |=> cnt_out[1];
   endproperty
   a_cfg_out: assert property (p_cfg_out) else $error("output not high after mode set");
endmodule : tcit_timer

// [verification/tcit_host.sv]
// Purpose: host software model driving the card register port
// Assumes: one-cycle wr/rd strobes, rdata registered on the taking edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module tcit_host
   import tcit_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic [7:0] rdata, // read data from the card
   output tcit_bus_t bus // register access strobes
);
   initial begin
      bus = '0;
   end

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      bus <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      bus <= '{1'b0, 1'b1, a, ~bus.wdata};
      @(posedge clock);
      bus <= '{1'b0, 1'b0, ~a, ~bus.wdata};
      #1;
      d = rdata;
   endtask : rd

   // two-byte counts move low byte first, as a pair
   task automatic wr16(input logic [5:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a, v[15:8]);
   endtask : wr16

   task automatic rd16(input logic [5:0] a, output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(a, lo);
      rd(a, hi);
      v = {hi, lo};
   endtask : rd16
endmodule : tcit_host

// [verification/tb.sv]
// Purpose: self-checking bench for the three channel interval timer
// Assumes: counter clocks come from the ext_clk pins, pulsed by the bench
// Notes: counts are compared as differences so the load-clock offset drops out
`timescale 1ns/1ps
module tb
   import tcit_pkg::*;
;
   logic clock, rst, ce, cascade_sel, irq_src_c1, irq_src_c2;
   logic [2:0] ext_clk, ext_clk_sel, gate_pin, gate_pin_used, cnt_out;
   logic [7:0] rdata, b;
   logic [15:0] va0, va1, vb;
   logic [31:0] seed;
   logic [5:0] prog;
   tcit_bus_t bus;
   int miscompares, checked, lows, highs;

   tcit_timer #(.NCH(3)) dut_u (.clock(clock), .rst(rst), .ce(ce), .bus(bus),
      .rdata(rdata), .ext_clk(ext_clk), .ext_clk_sel(ext_clk_sel),
      .cascade_sel(cascade_sel), .gate_pin(gate_pin), .gate_pin_used(gate_pin_used),
      .cnt_out(cnt_out), .irq_src_c1(irq_src_c1), .irq_src_c2(irq_src_c2));
   tcit_host host_u (.clock(clock), .rdata(rdata), .bus(bus));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   // out level right after mode set: low only in mode 0
   function automatic logic [7:0] exp_status(input logic [5:0] p);
      return {(p[3:1] != 3'h0), 1'b0, p};
   endfunction : exp_status

   task automatic summarize();
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   task automatic chk8(input logic [7:0] e, input logic [7:0] a);
      checked++;
      if (a !== e) begin
         miscompares++;
         $display("BAD %0t exp %h got %h", $time, e, a);
      end
   endtask : chk8

   task automatic chk16(input logic [15:0] e, input logic [15:0] a);
      checked++;
      if (a !== e) begin
         miscompares++;
         $display("BAD %0t exp %h got %h", $time, e, a);
      end
   endtask : chk16

   // one counter clock on all three pins, wide enough for the 2-flop sync
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clock);
         ext_clk <= 3'h7;
         repeat (6) @(posedge clock);
         ext_clk <= 3'h0;
         repeat (6) @(posedge clock);
         #1;
      end
   endtask : tick

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   initial begin
      repeat (30000) @(posedge clock);
      miscompares++;
      summarize();
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      cascade_sel = 1'b0;
      ext_clk = 3'h0;
      ext_clk_sel = 3'h7;
      gate_pin = 3'h7;
      gate_pin_used = 3'h0;
      seed = 32'd44;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk8(8'h00, rdata);
      chk8(8'h07, {5'h00, cnt_out});
      host_u.rd(6'h1C, b);
      chk8(8'h00, b);
      // each of the six modes on every counter, status read back through the data port
      for (int ch = 0; ch < 3; ch++) begin
         for (int m = 0; m < 6; m++) begin
            seed = xs(seed);
            prog = {2'h3, 3'(m), seed[1]};
            if (m == 2 || m == 3) prog[3] = seed[0];
            host_u.wr(TCIT_OFF_CTRL, {2'(ch), prog});
            host_u.wr(TCIT_OFF_CTRL, {4'hE, 3'(1 << ch), 1'b0});
            host_u.rd(TCIT_OFF_CNT0 + 6'(ch), b);
            chk8(exp_status(prog) & 8'hBF, b & 8'hBF);
         end
      end
      // counters 0 and 1 in mode 0, binary, large random counts
      host_u.wr(TCIT_OFF_CTRL, 8'h30);
      host_u.wr(TCIT_OFF_CTRL, 8'h70);
      repeat (2) @(posedge clock);
      #1;
      chk8(8'h00, {6'h00, cnt_out[1:0]});
      seed = xs(seed);
      host_u.wr16(TCIT_OFF_CNT0, 16'h8000 | seed[15:0]);
      host_u.wr16(TCIT_OFF_CNT1, 16'h8000 | seed[31:16]);
      tick(2);
      host_u.wr(TCIT_OFF_CTRL, 8'h00);
      host_u.wr(TCIT_OFF_CTRL, 8'h40);
      tick(3);
      host_u.rd16(TCIT_OFF_CNT0, va0);
      host_u.rd16(TCIT_OFF_CNT1, va1);
      chk16((16'h8000 | seed[15:0]) - 16'h0001, va0);
      chk16((16'h8000 | seed[31:16]) - 16'h0001, va1);
      // frozen clock enable must swallow these counter clocks
      ce <= 1'b0;
      tick(3);
      ce <= 1'b1;
      tick(2);
      host_u.wr(TCIT_OFF_CTRL, 8'hD6);
      tick(2);
      host_u.rd16(TCIT_OFF_CNT0, vb);
      chk16(va0 - 16'h0005, vb);
      host_u.rd16(TCIT_OFF_CNT1, vb);
      chk16(va1 - 16'h0005, vb);
      // counter 2 mode 0 with count 3 reaches terminal count
      host_u.wr(TCIT_OFF_CTRL, 8'hB0);
      host_u.wr16(TCIT_OFF_CNT2, 16'h0003);
      tick(2);
      chk8(8'h00, {7'h00, cnt_out[2]});
      tick(1);
      chk8(8'h00, {7'h00, cnt_out[2]});
      tick(1);
      chk8(8'h01, {7'h00, cnt_out[2]});
      tick(2);
      chk8(8'h01, {7'h00, cnt_out[2]});
      tick(3);
      chk8(8'h01, {7'h00, cnt_out[2]});
      // counter 1 mode 2 and counter 2 mode 3, both count 5, control words first then the counts
      host_u.wr(TCIT_OFF_CTRL, 8'h74);
      host_u.wr(TCIT_OFF_CTRL, 8'hB6);
      host_u.wr16(TCIT_OFF_CNT1, 16'h0005);
      host_u.wr16(TCIT_OFF_CNT2, 16'h0005);
      tick(5);
      lows = 0;
      highs = 0;
      // 30 clocks is six whole periods, so the load phase cannot skew the totals
      for (int i = 0; i < 30; i++) begin
         tick(1);
         lows += (cnt_out[1] == 1'b0);
         highs += (cnt_out[2] == 1'b1);
         chk8({6'h00, cnt_out[2:1]}, {6'h00, irq_src_c2, irq_src_c1});
      end
      chk8(8'd6, 8'(lows));
      chk8(8'd18, 8'(highs));
      // low gate on counter 1 holds its output high
      gate_pin <= 3'h5;
      gate_pin_used <= 3'h2;
      tick(2);
      for (int i = 0; i < 8; i++) begin
         tick(1);
         chk8(8'h01, {7'h00, cnt_out[1]});
      end
      // mode 4 on counter 0, modes 1 and 5 on gated counters 1 and 2, all count 3
      host_u.wr(TCIT_OFF_CTRL, 8'h38);
      host_u.wr(TCIT_OFF_CTRL, 8'h52);
      host_u.wr(TCIT_OFF_CTRL, 8'h9A);
      host_u.wr(TCIT_OFF_CNT1, 8'h03);
      host_u.wr(TCIT_OFF_CNT2, 8'h03);
      gate_pin_used <= 3'h6;
      // second pass retriggers both gated counters and reloads counter 0
      for (int p = 0; p < 2; p++) begin
         gate_pin <= 3'h0;
         tick(1);
         host_u.wr16(TCIT_OFF_CNT0, 16'h0003);
         gate_pin <= 3'h6;
         tick(3);
         chk8(8'h05, {5'h00, cnt_out});
         tick(1);
         chk8(8'h02, {5'h00, cnt_out});
         tick(1);
         chk8(8'h07, {5'h00, cnt_out});
      end
      summarize();
   end
endmodule : tb
